// file: avb_tx_credit_shaper_arbiter.sv
// Transmit arbiter choosing among AV, timing and legacy frame streams.
// Assumes byte wide AXI4-Stream sources and a MAC that takes one byte
// per cycle when it shows ready.
//
// Behaviour
// - Eligible queued AV frame goes first
// - Else send requested timing packet
// - Legacy only when no eligible AV or timing packet waits
// - AV allowed while credit at least zero
// - Negative credit blocks AV, legacy instead
// - No AV queued zeroes positive credit
// - Waiting AV gains idle slope per byte
// - Sending AV loses send slope per byte
// - Credit saturates at fixed internal limits
// - Send Slope Control holds idle increment
// - Idle Slope Control holds send decrement
// - Slope defaults 6144 and 2048 after reset
// - Byte based slopes, independent of speed
// - Over allowance at frame end switches legacy
// - Legacy path full duplex, no jumbo, VLAN
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`default_nettype none
`include "avb_arb_params.svh"
module avb_tx_credit_shaper_arbiter #(
  parameter int CREDIT_W = 24
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // AV stream source
  input  wire logic                 av_stream_valid,
  input  wire logic [7:0]           av_tdata,
  input  wire logic                 av_tlast,
  input  wire logic                 av_tuser,
  output logic                      av_tready,
  // Timing packet buffer source
  input  wire logic                 ptp_valid,
  input  wire logic [7:0]           ptp_tdata,
  input  wire logic                 ptp_tlast,
  output logic                      ptp_tready,
  // Legacy stream source
  input  wire logic                 legacy_valid,
  input  wire logic [7:0]           legacy_tdata,
  input  wire logic                 legacy_tlast,
  input  wire logic                 legacy_tuser,
  output logic                      legacy_tready,
  // MAC transmit path
  output logic                      mac_tvalid,
  output logic [7:0]                mac_tdata,
  output logic                      mac_tlast,
  output logic                      mac_tuser,
  input  wire logic                 mac_tready,
  // Register port
  input  wire logic [3:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [31:0]               reg_rdata
);
  // -----------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------
  logic [`SLOPE_W-1:0]          send_slope_ctrl_r; // Idle slope value
  logic [`SLOPE_W-1:0]          idle_slope_ctrl_r; // Send slope value
  logic signed [CREDIT_W-1:0]   credit;            // Shaper credit
  avb_arb_pkg::src_t            owner_r;           // Granted source
  avb_arb_pkg::src_t            owner_nxt;
  avb_arb_pkg::beat_t           beat;              // Selected beat
  logic                         out_valid_r;       // Output stage full
  avb_arb_pkg::beat_t           out_beat_r;        // Output stage data
  logic                         take;              // Beat accepted
  logic                         load;              // Output can load
  logic                         src_valid;         // Owner has beat

  // Address match helper, shared by write and read decode
  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction

  // Software writes the slopes; values are taken as given
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      send_slope_ctrl_r <= `SEND_SLOPE_CTRL_RST;
      idle_slope_ctrl_r <= `IDLE_SLOPE_CTRL_RST;
    end else if (reg_wr) begin
      if (hit(reg_addr, `REG_SEND_SLOPE_CTRL)) begin
        send_slope_ctrl_r <= reg_wdata[`SLOPE_W-1:0];
      end
      if (hit(reg_addr, `REG_IDLE_SLOPE_CTRL)) begin
        idle_slope_ctrl_r <= reg_wdata[`SLOPE_W-1:0];
      end
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      if (hit(reg_addr, `REG_SEND_SLOPE_CTRL)) begin
        reg_rdata <= {16'h0000, send_slope_ctrl_r};
      end else if (hit(reg_addr, `REG_IDLE_SLOPE_CTRL)) begin
        reg_rdata <= {16'h0000, idle_slope_ctrl_r};
      end else if (hit(reg_addr, `REG_CREDIT_STATUS)) begin
        reg_rdata <= 32'(credit); // Sign extended credit
      end else if (hit(reg_addr, `REG_ARB_STATUS)) begin
        reg_rdata <= {30'h0000_0000, owner_r};
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // -----------------------------------------------------------------
  // Arbitration
  // -----------------------------------------------------------------
  // Grant choice when idle; a granted frame is never preempted
  always_comb begin
    owner_nxt = owner_r;
    if (owner_r == avb_arb_pkg::SRC_NONE) begin
      if (av_stream_valid && credit >= `CREDIT_ZERO) begin
        owner_nxt = avb_arb_pkg::SRC_AV;
      end else if (ptp_valid) begin
        owner_nxt = avb_arb_pkg::SRC_PTP;
      end else if (legacy_valid) begin
        owner_nxt = avb_arb_pkg::SRC_LEGACY;
      end
    end else if (take && beat.tlast) begin
      // Back to idle, so the next pick sees fresh credit; AV valid
      // held high does not park the arbiter once credit is negative
      owner_nxt = avb_arb_pkg::SRC_NONE;
    end
  end

  // Owner register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      owner_r <= avb_arb_pkg::SRC_NONE;
    end else begin
      owner_r <= owner_nxt;
    end
  end

  // Beat mux from the granted source
  always_comb begin
    beat      = '0;
    src_valid = 1'b0;
    case (owner_r)
      avb_arb_pkg::SRC_AV: begin
        beat      = {av_tdata, av_tlast, av_tuser};
        src_valid = av_stream_valid;
      end
      avb_arb_pkg::SRC_PTP: begin
        beat      = {ptp_tdata, ptp_tlast, 1'b0};
        src_valid = ptp_valid;
      end
      avb_arb_pkg::SRC_LEGACY: begin
        beat      = {legacy_tdata, legacy_tlast, legacy_tuser};
        src_valid = legacy_valid;
      end
      default: begin
        beat      = '0;
        src_valid = 1'b0;
      end
    endcase
  end

  // -----------------------------------------------------------------
  // Output stage
  // -----------------------------------------------------------------
  // One register stage; loads when empty or being drained
  assign load = !out_valid_r || mac_tready;
  assign take = load && src_valid;

  // Ready back to the granted source only
  assign av_tready     = load && (owner_r == avb_arb_pkg::SRC_AV);
  assign ptp_tready    = load && (owner_r == avb_arb_pkg::SRC_PTP);
  assign legacy_tready = load && (owner_r == avb_arb_pkg::SRC_LEGACY);

  // Stage valid
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_valid_r <= 1'b0;
    end else if (load) begin
      out_valid_r <= take;
    end
  end

  // Stage data
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_beat_r <= '0;
    end else if (take) begin
      out_beat_r <= beat;
    end
  end

  assign mac_tvalid = out_valid_r;
  assign mac_tdata  = out_beat_r.tdata;
  assign mac_tlast  = out_beat_r.tlast;
  assign mac_tuser  = out_beat_r.tuser;

  // -----------------------------------------------------------------
  // Shaper
  // -----------------------------------------------------------------
  // Credit moves per byte taken, so link speed does not matter
  avb_credit_shaper #(
    .CREDIT_W (CREDIT_W)
  ) u_shaper (
    .clk             (clk),
    .sys_rst         (sys_rst),
    .idle_slope      (send_slope_ctrl_r),
    .send_slope      (idle_slope_ctrl_r),
    .av_queued       (av_stream_valid),
    .av_byte_sent    (take && owner_r == avb_arb_pkg::SRC_AV),
    .other_byte_sent (take && owner_r != avb_arb_pkg::SRC_AV),
    .credit_r        (credit)
  );
endmodule
`default_nettype wire

// file: avb_arb_params.svh
// Named constants for the AVB transmit credit shaper arbiter.
// Assumes it is included once per file by its bare name.
`ifndef AVB_ARB_PARAMS_SVH
`define AVB_ARB_PARAMS_SVH

// -----------------------------------------------------------------
// Register indices (plain register port, word addressed)
// -----------------------------------------------------------------
`define REG_SEND_SLOPE_CTRL  4'h0
`define REG_IDLE_SLOPE_CTRL  4'h1
`define REG_CREDIT_STATUS    4'h2
`define REG_ARB_STATUS       4'h3

// -----------------------------------------------------------------
// Reset values and limits
// -----------------------------------------------------------------
`define SEND_SLOPE_CTRL_RST  16'h1800
`define IDLE_SLOPE_CTRL_RST  16'h0800
`define CREDIT_HI_LIMIT      24'sh0FFFFF
`define CREDIT_LO_LIMIT      -24'sh100000
`define CREDIT_ZERO          24'sh000000
`define SLOPE_W              16

`endif

// file: avb_arb_pkg.sv
// Types shared by the AVB transmit arbiter files.
// Assumes the params header is available on the include path.
`default_nettype none
package avb_arb_pkg;
  // Source currently owning the MAC transmit path
  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_AV,
    SRC_PTP,
    SRC_LEGACY
  } src_t;

  // One AXI4-Stream byte beat
  typedef struct packed {
    logic [7:0] tdata;
    logic       tlast;
    logic       tuser;
  } beat_t;
endpackage
`default_nettype wire

// file: avb_credit_shaper.sv
// Credit-based shaper: byte based credit with saturation.
// Assumes one byte per accepted beat, so it is independent of speed.
`default_nettype none
`include "avb_arb_params.svh"
module avb_credit_shaper #(
  parameter int CREDIT_W = 24
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  // Slopes from software
  input  wire logic [`SLOPE_W-1:0]        idle_slope,
  input  wire logic [`SLOPE_W-1:0]        send_slope,
  // Events
  input  wire logic                       av_queued,
  input  wire logic                       av_byte_sent,
  input  wire logic                       other_byte_sent,
  // Credit out
  output logic signed [CREDIT_W-1:0]      credit_r
);
  // -----------------------------------------------------------------
  // Credit update
  // -----------------------------------------------------------------
  logic signed [CREDIT_W:0] sum;   // One extra bit keeps overflow visible
  logic signed [CREDIT_W-1:0] credit_nxt;

  // Next credit, clamped to the fixed limits
  always_comb begin
    sum = {credit_r[CREDIT_W-1], credit_r};
    if (av_byte_sent) begin
      sum = sum - $signed({1'b0, {(CREDIT_W-`SLOPE_W){1'b0}},
                            send_slope});
    end else if (av_queued && other_byte_sent) begin
      sum = sum + $signed({1'b0, {(CREDIT_W-`SLOPE_W){1'b0}},
                            idle_slope});
    end
    if (sum > $signed({`CREDIT_HI_LIMIT})) begin
      credit_nxt = `CREDIT_HI_LIMIT;
    end else if (sum < $signed({`CREDIT_LO_LIMIT})) begin
      credit_nxt = `CREDIT_LO_LIMIT;
    end else begin
      credit_nxt = sum[CREDIT_W-1:0];
    end
    // Idle AV queue loses positive credit; deficit is kept
    if (!av_queued && !av_byte_sent && credit_nxt > `CREDIT_ZERO) begin
      credit_nxt = `CREDIT_ZERO;
    end
  end

  // Credit register; counts per byte so speed changes need no rescale
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      credit_r <= `CREDIT_ZERO;
    end else begin
      credit_r <= credit_nxt;
    end
  end
endmodule
`default_nettype wire

// file: avb_arb_checker.sv
// Port checks on the transmit arbiter.
// Assumes a bind into the arbiter top; sees its ports only.
`default_nettype none
module avb_arb_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Source handshakes
  input wire logic        av_stream_valid,
  input wire logic        av_tready,
  input wire logic        av_tlast,
  input wire logic        ptp_valid,
  input wire logic        ptp_tready,
  input wire logic        ptp_tlast,
  input wire logic        legacy_valid,
  input wire logic        legacy_tready,
  input wire logic        legacy_tlast,
  // MAC and registers
  input wire logic        mac_tvalid,
  input wire logic        mac_tready,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ---------------------------------------------------------
  // Frame tracking from the takes alone
  // ---------------------------------------------------------
  wire  t_av  = av_stream_valid & av_tready;
  wire  t_pt  = ptp_valid & ptp_tready;
  wire  t_lg  = legacy_valid & legacy_tready;
  wire  t_any = t_av | t_pt | t_lg;
  wire  t_end = t_av & av_tlast | t_pt & ptp_tlast | t_lg & legacy_tlast;
  logic mid_r;  // Inside a frame, so no new grant
  logic av_r;   // Frame in flight is from the AV stream
  // Owner is caught on the first take of each frame
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mid_r <= 1'b0;
      av_r  <= 1'b0;
    end else if (t_any) begin
      mid_r <= !t_end;
      av_r  <= mid_r ? av_r : t_av;
    end
  end
  sequence s_end;
    t_end;
  endsequence
  sequence s_leg_start;
    t_lg && !mid_r;
  endsequence
  AST_ONE_GRANT: assert property (
    $onehot0({av_tready, ptp_tready, legacy_tready}))
    else $error("two sources granted");
  AST_NO_PREEMPT: assert property (mid_r |->
    (av_r ? !(ptp_tready | legacy_tready) : !av_tready))
    else $error("frame preempted");
  AST_IDLE_GAP: assert property (s_end |=>
    !(av_tready | ptp_tready | legacy_tready))
    else $error("no idle cycle after frame end");
  AST_MAC_LOAD: assert property (t_any |=> mac_tvalid)
    else $error("taken byte not offered to MAC");
  AST_MAC_HOLD: assert property (
    (mac_tvalid && !mac_tready)[*2] |=> mac_tvalid)
    else $error("MAC beat dropped while stalled");
  AST_LEG_LAST: assert property (s_leg_start |-> !ptp_valid)
    else $error("legacy granted over timing packet");
  AST_RD_QUIET: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  AST_RST_QUIET: assert property (
    $fell(sys_rst) |-> !mac_tvalid && !t_any)
    else $error("activity straight after reset");
endmodule
bind avb_tx_credit_shaper_arbiter avb_arb_checker chk (
  .clk(clk), .sys_rst(sys_rst), .av_stream_valid(av_stream_valid),
  .av_tready(av_tready), .av_tlast(av_tlast), .ptp_valid(ptp_valid),
  .ptp_tready(ptp_tready), .ptp_tlast(ptp_tlast),
  .legacy_valid(legacy_valid), .legacy_tready(legacy_tready),
  .legacy_tlast(legacy_tlast), .mac_tvalid(mac_tvalid),
  .mac_tready(mac_tready), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
`default_nettype wire

// file: avb_src_model.sv
// Frame source feeding one arbiter input stream.
// Assumes the bench adds whole frames; bytes carry a source tag.
`default_nettype none
module avb_src_model #(
  parameter logic [1:0] TAG = 2'h1,  // Marks bytes of this source
  parameter int         LEN = 2      // Bytes per frame
) (
  // Clock and reset
  input wire logic           clk,
  input wire logic           sys_rst,
  // Bench control and handshake
  input wire logic [3:0]     add,
  input wire logic           tready,
  output logic               valid,
  output avb_arb_pkg::beat_t beat
);
  logic [3:0] frames_r;  // Whole frames queued
  logic [5:0] pos_r;     // Byte position in frame
  wire        last = pos_r == 6'(LEN - 1);
  wire        take = valid & tready;
  // Valid spans frames while more wait, drops at once otherwise
  assign valid = frames_r != 4'h0;
  // Idle data inverted so a stale byte never passes
  assign beat = '{tdata: valid ? {TAG, pos_r} : ~{TAG, pos_r},
                  tlast: valid & last, tuser: 1'b0};
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      frames_r <= 4'h0;
      pos_r    <= 6'h00;
    end else begin
      frames_r <= frames_r + add - {3'h0, take & last};
      pos_r    <= take ? (last ? 6'h00 : pos_r + 6'h01) : pos_r;
    end
  end
endmodule
`default_nettype wire

// file: tb_top.sv
// Bench: three frame sources, stalling MAC sink, register port.
// Assumes package, header, checker and source model come first.
`default_nettype none
`include "avb_arb_params.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AVL = 20;  // Long enough to reach the low limit
  localparam int PTL = 2;
  localparam int LGL = 8;
  logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic mac_tready = 1'b0, av_v, pt_v, lg_v, av_r, pt_r, lg_r;
  logic mac_tvalid, mac_tlast, mac_tuser;
  logic [3:0] reg_addr = 4'h0, add_av = 4'h0, add_pt = 4'h0;
  logic [3:0] add_lg = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [7:0] mac_tdata;
  avb_arb_pkg::beat_t av_b, pt_b, lg_b;
  int n_errors = 0, checks = 0, cyc = 0;
  logic [7:0] exp_q[$];  // Bytes due at the MAC, in order
  logic [1:0] exp_lu[$]; // Last and user flags due, same order
  always #10 clk = ~clk;
  avb_tx_credit_shaper_arbiter uut (.clk(clk), .sys_rst(sys_rst),
    .av_stream_valid(av_v), .av_tdata(av_b.tdata),
    .av_tlast(av_b.tlast), .av_tuser(av_b.tuser), .av_tready(av_r),
    .ptp_valid(pt_v), .ptp_tdata(pt_b.tdata), .ptp_tlast(pt_b.tlast),
    .ptp_tready(pt_r), .legacy_valid(lg_v), .legacy_tdata(lg_b.tdata),
    .legacy_tlast(lg_b.tlast), .legacy_tuser(lg_b.tuser),
    .legacy_tready(lg_r), .mac_tvalid(mac_tvalid),
    .mac_tdata(mac_tdata), .mac_tlast(mac_tlast),
    .mac_tuser(mac_tuser), .mac_tready(mac_tready),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  avb_src_model #(.TAG(2'h1), .LEN(AVL)) av_src (.clk(clk),
    .sys_rst(sys_rst), .add(add_av), .tready(av_r), .valid(av_v),
    .beat(av_b));
  avb_src_model #(.TAG(2'h2), .LEN(PTL)) pt_src (.clk(clk),
    .sys_rst(sys_rst), .add(add_pt), .tready(pt_r), .valid(pt_v),
    .beat(pt_b));
  avb_src_model #(.TAG(2'h3), .LEN(LGL)) lg_src (.clk(clk),
    .sys_rst(sys_rst), .add(add_lg), .tready(lg_r), .valid(lg_v),
    .beat(lg_b));
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: read %h, want %h", $time, g, e);
    end
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: MAC byte %h, want %h", $time, g, e);
    end
  endtask
  task automatic chk2(input logic [1:0] g, input logic [1:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: MAC last/user %b, want %b", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk32(reg_rdata, e);
  endtask
  // Expected bytes of one frame, queued before it is offered
  task automatic ex(input logic [1:0] t, input int len);
    for (int i = 0; i < len; i++) begin
      exp_q.push_back({t, 6'(i)});
      exp_lu.push_back({(i == len - 1), 1'b0});
    end
  endtask
  task automatic qf(input logic [3:0] a, input logic [3:0] p,
                    input logic [3:0] l);
    @(posedge clk);
    add_av <= a;
    add_pt <= p;
    add_lg <= l;
    @(posedge clk);
    add_av <= 4'h0;
    add_pt <= 4'h0;
    add_lg <= 4'h0;
    while (exp_q.size() != 0) @(posedge clk);
  endtask
  task automatic results();
    $display("Counts: %0d errors, %0d checks", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Sink stalls one cycle in three; a hang is cut by the ceiling
  always @(posedge clk) begin
    cyc <= cyc + 1;
    mac_tready <= (cyc % 3) != 0;
    if (cyc == 5000) begin
      n_errors++;
      results();
    end
    if (!sys_rst && mac_tvalid === 1'b1 && mac_tready) begin
      chk2({mac_tlast, mac_tuser},
           exp_lu.size() ? exp_lu.pop_front() : 2'bXX);
      chk8(mac_tdata, exp_q.size() ? exp_q.pop_front() : 8'hXX);
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`REG_SEND_SLOPE_CTRL, 32'h00001800);
    rd(`REG_IDLE_SLOPE_CTRL, 32'h00000800);
    rd(`REG_ARB_STATUS, 32'h00000000);
    rd(4'hF, 32'h00000000);
    wr(`REG_CREDIT_STATUS, 32'h00001234);
    rd(`REG_CREDIT_STATUS, 32'h00000000);
    ex(2'h1, AVL);
    ex(2'h2, PTL);
    ex(2'h3, LGL);
    ex(2'h1, AVL);
    qf(4'h2, 4'h1, 4'h1);
    rd(`REG_CREDIT_STATUS, 32'(-2 * AVL * 2048 + (PTL + LGL) * 6144));
    // Light send slope, so AV leaves the queue while in credit
    wr(`REG_IDLE_SLOPE_CTRL, 32'h00000100);
    ex(2'h3, LGL);
    ex(2'h1, AVL);
    qf(4'h1, 4'h0, 4'h1);
    rd(`REG_CREDIT_STATUS, 32'h00000000);
    wr(`REG_IDLE_SLOPE_CTRL, 32'h0000FFFF);
    rd(`REG_IDLE_SLOPE_CTRL, 32'h0000FFFF);
    ex(2'h1, AVL);
    qf(4'h1, 4'h0, 4'h0);
    rd(`REG_CREDIT_STATUS, 32'hFFF00000);
    rd(`REG_SEND_SLOPE_CTRL, 32'h00001800);
    results();
  end
endmodule
`default_nettype wire
